/* File: hw/sbc_config_diag_encoding.sv */
// Operation
// - code 00 keeps previous threshold
// - codes 01,10,11 pick levels one to three
// - watchdog period from two linear formulas
// - restart cause encoded in two bits
// - read-only diagnostic read clears restart cause
// - leaving sleep or fail-safe clears cause
// - safe output off clears its cause
// - safe output cause held as three bits
// - strap, test pin, wd bit readable
// - configs one to four coded 000-011
// - top bit set means development mode
// - diagnostic fields are output only
// - write commands answer previous command
// - first normal frame reports previous mode
// - automatic first frame clears nothing
// - bad watchdog parity drops the write
// - read-only answers same frame, no write
// - read-only clears selected interrupt bits
module sbc_config_diag_encoding
   import sbc_cfg_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
   input  wire logic                            clk,
   input  wire logic                            sys_rst,
   input  wire logic                            frame_start,
   input  wire logic                            frame_done,
   input  wire logic [sbc_cfg_pkg::FRAME_W-1:0] frame_in,
   input  wire logic                            wd_kick,
   input  wire logic                            ev_host_uv,
   input  wire logic                            ev_wd_first,
   input  wire logic                            ev_wake_nack,
   input  wire logic                            ev_flash_ext,
   input  wire logic                            safe_set,
   input  wire logic [2:0]                      safe_cause_in,
   input  wire logic                            leave_sleep,
   input  wire logic                            leave_failsafe,
   input  wire logic                            enter_normal,
   input  wire logic [2:0]                      prev_mode,
   input  wire logic                            restart_by_host,
   input  wire logic                            strap_cfg,
   input  wire logic                            test_pin,
   input  wire logic [sbc_cfg_pkg::PAY_W-1:0]   wake_flags,
   output logic [sbc_cfg_pkg::FRAME_W-1:0]      tx_frame,
   output logic                                 threshold_sel_hi,
   output logic                                 threshold_sel_lo,
   output logic                                 undervolt_level_one,
   output logic                                 undervolt_level_two,
   output logic                                 undervolt_level_three,
   output logic [4:0]                           wd_period,
   output logic                                 wd_expired,
   output logic                                 wd_fail_action,
   output logic                                 fail_safe_output,
   output logic                                 wdfail_to_safe_out,
   output logic                                 restart_cause_hi,
   output logic                                 restart_cause_lo,
   output logic                                 safe_out_cause_b2,
   output logic                                 safe_out_cause_b1,
   output logic                                 safe_out_cause_b0,
   output logic                                 strap_readout_b2,
   output logic                                 strap_readout_b1,
   output logic                                 strap_readout_b0,
   output logic                                 sw_dev_mode,
   output logic                                 ro_clear,
   output logic [2:0]                           ro_clear_sel
);
   import sbc_cfg_pkg::*;

   logic [1:0]         thr_sel,    next_thr_sel;
   logic [4:0]         next_wd_period;
   logic               next_safe,  next_wdts, next_ro_clear;
   logic [1:0]         rcause,     next_rcause;
   logic [2:0]         scause,     next_scause;
   logic               strap_q,    next_strap_q;
   logic               test_q,     next_test_q;
   logic               strap_done, next_strap_done;
   logic [FRAME_W-1:0] pending,    next_pending, next_tx_frame;
   logic               pend_load,  next_pend_load;
   logic [2:0]         pend_sel,   next_pend_sel;
   logic [2:0]         pend_mode,  next_pend_mode;
   logic [2:0]         next_ro_clear_sel;
   logic               wd_restart, next_wd_restart;
   logic [2:0]         hdr_mode, hdr_sel;
   logic               is_ro, is_wr, parity_ok;
   logic [PAY_W-1:0]   wr_pay;
   logic [2:0]         readout;
   logic [1:0]         rc_event;
   logic               rc_hit;
   logic [PAY_W-1:0]   pay_now, pay_pend;

   assign hdr_mode  = frame_in[MODE_LSB +: 3];
   assign hdr_sel   = frame_in[SEL_LSB +: 3];
   assign wr_pay    = frame_in[PAY_MSB:PAY_LSB];
   assign is_ro     = (hdr_mode == MODE_READ_ONLY);
   // diagnostic select carries no writable bits at all
   assign is_wr     = frame_done && !is_ro && (hdr_sel != SEL_DIAG);
   assign parity_ok = ((^frame_in[PAY_MSB:PAY_LSB]) == frame_in[PARITY_POS]);

   // config code: bit0 strap (supply off), bit1 two-failure setting
   assign readout = {test_q, wdfail_to_safe_out, strap_q};
   assign sw_dev_mode = readout[2];

   // payload of a selectable register from present state
   function automatic logic [PAY_W-1:0] payload_of(input logic [2:0] sel);
      logic [PAY_W-1:0] p;
      p = '0;
      unique case (sel)
         SEL_WAKE: p = wake_flags;
         SEL_CFG: begin
            p[CFG_THR_LSB +: 2] = thr_sel;
            p[CFG_SAFE_POS]     = fail_safe_output;
            p[CFG_WDTS_POS]     = wdfail_to_safe_out;
         end
         SEL_WD: p[WD_PER_LSB +: 5] = wd_period;
         SEL_DIAG: begin
            p[DIAG_RC_LSB +: 2] = rcause;
            p[DIAG_SC_LSB +: 3] = scause;
            p[DIAG_ST_LSB +: 3] = readout;
         end
         default: p = '0; // communication and unused selects read zero
      endcase
      return p;
   endfunction : payload_of

   // processes, not assigns: registers read inside the function wake them
   always_comb pay_now  = payload_of(hdr_sel);
   always_comb pay_pend = payload_of(pend_sel);

   // restart cause priority: external beats watchdog beats undervoltage
   always_comb begin
      rc_hit   = 1'b1;
      rc_event = RC_NONE;
      if (ev_flash_ext) begin
         rc_event = RC_EXT;
      end else if (ev_wd_first || ev_wake_nack) begin
         rc_event = RC_WD;
      end else if (ev_host_uv) begin
         rc_event = RC_UV;
      end else if (safe_set) begin
         rc_event = RC_NONE;
      end else begin
         rc_hit = 1'b0;
      end
   end

   // configuration writes and diagnostic flags; a set beats a clear
   always_comb begin
      next_thr_sel   = thr_sel;
      next_wd_period = wd_period;
      next_safe      = fail_safe_output;
      next_wdts      = wdfail_to_safe_out;
      next_rcause    = rcause;
      next_scause    = scause;
      next_wd_restart = wd_kick;
      if (is_wr && hdr_sel == SEL_CFG) begin
         if (wr_pay[CFG_THR_LSB +: 2] != THR_INVALID) begin
            next_thr_sel = wr_pay[CFG_THR_LSB +: 2];
         end
         next_safe = wr_pay[CFG_SAFE_POS];
         next_wdts = wr_pay[CFG_WDTS_POS];
         if (!wr_pay[CFG_SAFE_POS]) begin
            next_scause = SC_NONE;
         end
      end
      if (is_wr && hdr_sel == SEL_WD && parity_ok) begin
         next_wd_period  = wr_pay[WD_PER_LSB +: 5];
         next_wd_restart = 1'b1;
      end
      if ((frame_done && is_ro && hdr_sel == SEL_DIAG)
          || leave_sleep || leave_failsafe) begin
         next_rcause = RC_NONE;
      end
      if (rc_hit) begin
         next_rcause = rc_event;
      end
      if (safe_set) begin
         next_safe   = 1'b1;
         next_scause = safe_cause_in;
      end
   end

   // answer path: read-only now, everything else one command late
   always_comb begin
      next_tx_frame     = tx_frame;
      next_pending      = pending;
      next_pend_load    = 1'b0;
      next_pend_sel     = pend_sel;
      next_pend_mode    = pend_mode;
      next_ro_clear     = 1'b0;
      next_ro_clear_sel = ro_clear_sel;
      if (frame_start) begin
         if (is_ro) begin
            next_tx_frame = {2'h0, pay_now, hdr_sel, hdr_mode};
         end else begin
            next_tx_frame = pending;
         end
      end
      if (frame_done && is_ro) begin
         next_ro_clear     = 1'b1;
         next_ro_clear_sel = hdr_sel;
      end else if (frame_done) begin
         // snapshot one cycle later so the answer shows this write
         next_pend_load = 1'b1;
         next_pend_sel  = hdr_sel;
         next_pend_mode = hdr_mode;
      end else if (enter_normal) begin
         next_pend_load = 1'b1;
         next_pend_mode = prev_mode;
         unique case (prev_mode)
            MODE_SLEEP:    next_pend_sel = SEL_WAKE;
            MODE_FAILSAFE: next_pend_sel = SEL_DIAG;
            MODE_RESTART:  next_pend_sel = (!restart_by_host && !strap_q)
                                           ? SEL_DIAG : SEL_CFG;
            default:       next_pend_sel = SEL_CFG;
         endcase
      end
      // the snapshot only reads; clearing waits for a read-only request
      if (pend_load) begin
         next_pending = {2'h0, pay_pend, pend_sel, pend_mode};
      end
   end

   // strap and test pin are caught once, on the first edge after reset
   always_comb begin
      next_strap_done = 1'b1;
      next_strap_q    = strap_done ? strap_q : strap_cfg;
      next_test_q     = strap_done ? test_q : test_pin;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         thr_sel            <= THR_RESET;
         wd_period          <= WD_PER_RESET;
         fail_safe_output   <= SAFE_RESET;
         wdfail_to_safe_out <= WDTS_RESET;
         rcause             <= RC_NONE;
         scause             <= SC_NONE;
         strap_q            <= 1'b0;
         test_q             <= 1'b0;
         strap_done         <= 1'b0;
         tx_frame           <= '0;
         pending            <= '0;
         pend_load          <= 1'b0;
         pend_sel           <= SEL_CFG;
         pend_mode          <= MODE_INIT;
         ro_clear           <= 1'b0;
         ro_clear_sel       <= SEL_WAKE;
         wd_restart         <= 1'b1;
      end else begin
         thr_sel            <= next_thr_sel;
         wd_period          <= next_wd_period;
         fail_safe_output   <= next_safe;
         wdfail_to_safe_out <= next_wdts;
         rcause             <= next_rcause;
         scause             <= next_scause;
         strap_q            <= next_strap_q;
         test_q             <= next_test_q;
         strap_done         <= next_strap_done;
         tx_frame           <= next_tx_frame;
         pending            <= next_pending;
         pend_load          <= next_pend_load;
         pend_sel           <= next_pend_sel;
         pend_mode          <= next_pend_mode;
         ro_clear           <= next_ro_clear;
         ro_clear_sel       <= next_ro_clear_sel;
         wd_restart         <= next_wd_restart;
      end
   end

   assign threshold_sel_hi  = thr_sel[1];
   assign threshold_sel_lo  = thr_sel[0];
   assign restart_cause_hi  = rcause[1];
   assign restart_cause_lo  = rcause[0];
   assign safe_out_cause_b2 = scause[2];
   assign safe_out_cause_b1 = scause[1];
   assign safe_out_cause_b0 = scause[0];
   assign strap_readout_b2  = readout[2];
   assign strap_readout_b1  = readout[1];
   assign strap_readout_b0  = readout[0];
   // development mode swallows the failure action, not the timeout
   assign wd_fail_action    = wd_expired && !sw_dev_mode;

   sbc_threshold_decode u_thr (
      .thr_sel               (thr_sel),
      .undervolt_level_one   (undervolt_level_one),
      .undervolt_level_two   (undervolt_level_two),
      .undervolt_level_three (undervolt_level_three)
   );

   sbc_wd_timer #(.TICK_CYCLES(TICK_CYCLES)) u_wd (
      .clk     (clk),
      .sys_rst (sys_rst),
      .period  (wd_period),
      .restart (wd_restart),
      .expired (wd_expired)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   thr_keep_a: assert property (is_wr && hdr_sel == SEL_CFG
      && wr_pay[1:0] == 2'h0 |=> $stable(thr_sel))
      else $error("threshold changed on invalid code");
   thr_level_a: assert property (undervolt_level_one == (thr_sel == 2'h1)
      && thr_sel != 2'h0)
      else $error("threshold level decode wrong");
   rc_read_a: assert property (frame_done && is_ro
      && hdr_sel == SEL_DIAG && !rc_hit |=> rcause == 2'h0)
      else $error("restart cause not cleared by read");
   rc_leave_a: assert property ((leave_sleep || leave_failsafe)
      && !rc_hit |=> rcause == 2'h0)
      else $error("restart cause not cleared on leave");
   rc_ext_a: assert property (ev_flash_ext |=> rcause == 2'h3)
      else $error("external restart cause lost");
   sc_off_a: assert property (is_wr && hdr_sel == SEL_CFG
      && !wr_pay[2] && !safe_set |=> scause == 3'h0 && !fail_safe_output)
      else $error("safe cause not cleared");
   ro_same_a: assert property (frame_start && is_ro
      |=> tx_frame[5:0] == $past(frame_in[5:0]))
      else $error("read-only header not echoed");
   prev_resp_a: assert property (frame_done && !is_ro
      |=> ##1 pending[5:3] == $past(frame_in[5:3], 2))
      else $error("answer not for previous command");
   first_mode_a: assert property (enter_normal && !frame_done
      |=> ##1 pending[2:0] == $past(prev_mode, 2))
      else $error("first frame mode wrong");
   dev_mode_a: assert property (sw_dev_mode |-> !wd_fail_action)
      else $error("failure action in development mode");
   wd_parity_a: assert property (is_wr && hdr_sel == SEL_WD
      && !parity_ok |=> $stable(wd_period))
      else $error("watchdog write with bad parity taken");

   ro_cov_c:    cover property (frame_start && is_ro ##[1:20] frame_done);
   first_cov_c: cover property (enter_normal ##2 frame_start);
   wd_cov_c:    cover property (wd_expired);
   safe_cov_c:  cover property (safe_set ##[1:50] is_wr && !wr_pay[2]);

endmodule : sbc_config_diag_encoding

/* File: hw/sbc_threshold_decode.sv */
module sbc_threshold_decode
   import sbc_cfg_pkg::*;
(
   input  wire logic [1:0] thr_sel,
   output logic            undervolt_level_one,
   output logic            undervolt_level_two,
   output logic            undervolt_level_three
);

   // one-hot level select; code 00 never reaches here, it is filtered
   always_comb begin
      undervolt_level_one   = (thr_sel == 2'h1);
      undervolt_level_two   = (thr_sel == 2'h2);
      undervolt_level_three = (thr_sel == 2'h3);
   end

endmodule : sbc_threshold_decode

/* File: hw/sbc_wd_timer.sv */
module sbc_wd_timer
   import sbc_cfg_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   input  wire logic [4:0] period,
   input  wire logic       restart,
   output logic            expired
);

   logic [TICK_W-1:0] div;
   logic [TICK_W-1:0] next_div;
   logic [MS_W-1:0]   ms;
   logic [MS_W-1:0]   next_ms;
   logic [MS_W-1:0]   limit;
   logic              tick;
   logic              next_expired;

   // two linear segments keep the table out of a rom
   always_comb begin
      if (period < WD_SPLIT) begin
         limit = (MS_W'(period) + 11'h001) * WD_STEP_LO;
      end else begin
         limit = MS_W'(MS_W'(period) * WD_STEP_HI - WD_OFS_HI);
      end
   end

   // 1 ms time base, then a millisecond count up to the limit
   always_comb begin
      tick         = (div == TICK_W'(TICK_CYCLES - 1));
      next_div     = tick ? '0 : div + 1'b1;
      next_ms      = ms;
      next_expired = 1'b0;
      if (restart) begin
         next_div = '0;
         next_ms  = '0;
      end else if (tick) begin
         if (ms + 1'b1 >= limit) begin
            next_ms      = '0;
            next_expired = 1'b1;
         end else begin
            next_ms = ms + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         div     <= '0;
         ms      <= '0;
         expired <= 1'b0;
      end else begin
         div     <= next_div;
         ms      <= next_ms;
         expired <= next_expired;
      end
   end

endmodule : sbc_wd_timer

/* File: include/sbc_cfg_pkg.sv */
package sbc_cfg_pkg;

   // frame layout: mode bits, select bits, payload above them
   localparam int FRAME_W   = 16;
   localparam int PAY_W     = 8;
   localparam int MODE_LSB  = 0;
   localparam int SEL_LSB   = 3;
   localparam int PAY_LSB   = 6;
   localparam int PAY_MSB   = 13;
   localparam int PARITY_POS = 15;

   // mode select codes
   localparam logic [2:0] MODE_INIT      = 3'h0;
   localparam logic [2:0] MODE_RESTART   = 3'h1;
   localparam logic [2:0] MODE_FAILSAFE  = 3'h2;
   localparam logic [2:0] MODE_SLEEP     = 3'h3;
   localparam logic [2:0] MODE_NORMAL    = 3'h4;
   localparam logic [2:0] MODE_FLASH     = 3'h5;
   localparam logic [2:0] MODE_READ_ONLY = 3'h7;

   // configuration select codes
   localparam logic [2:0] SEL_WAKE = 3'h0;
   localparam logic [2:0] SEL_CFG  = 3'h4;
   localparam logic [2:0] SEL_COMM = 3'h5;
   localparam logic [2:0] SEL_WD   = 3'h6;
   localparam logic [2:0] SEL_DIAG = 3'h7;

   // payload field positions (payload bit 0 is frame bit 6)
   localparam int CFG_THR_LSB   = 0;
   localparam int CFG_SAFE_POS  = 2;
   localparam int CFG_WDTS_POS  = 3;
   localparam int WD_PER_LSB    = 0;
   localparam int DIAG_RC_LSB   = 0;
   localparam int DIAG_SC_LSB   = 2;
   localparam int DIAG_ST_LSB   = 5;

   // values after reset, and the refused threshold code
   localparam logic [1:0] THR_RESET    = 2'h1;
   localparam logic [1:0] THR_INVALID  = 2'h0;
   localparam logic [4:0] WD_PER_RESET = 5'h0F;
   localparam logic       WDTS_RESET   = 1'b1;
   localparam logic       SAFE_RESET   = 1'b0;

   // restart cause codes, and the empty safe output cause
   localparam logic [1:0] RC_NONE  = 2'h0;
   localparam logic [1:0] RC_UV    = 2'h1;
   localparam logic [1:0] RC_WD    = 2'h2;
   localparam logic [1:0] RC_EXT   = 2'h3;
   localparam logic [2:0] SC_NONE  = 3'h0;

   // watchdog timing
   localparam int  CLK_PERIOD_NS  = 100;
   localparam int  TIME_BASE_MS   = 1;
   localparam int  TICK_CYCLES_DEF = TIME_BASE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int  TICK_W         = 16;
   localparam int  MS_W           = 11;
   localparam logic [MS_W-1:0] WD_STEP_LO = 11'h010;
   localparam logic [MS_W-1:0] WD_STEP_HI = 11'h030;
   localparam logic [MS_W-1:0] WD_OFS_HI  = 11'h1D0;
   localparam logic [4:0]      WD_SPLIT   = 5'h10;

endpackage : sbc_cfg_pkg

/* File: testbench/sbc_host_model.sv */
module sbc_host_model
   import sbc_cfg_pkg::*;
(
   input  wire logic [sbc_cfg_pkg::FRAME_W-1:0] tx_frame,
   input  wire logic                            clk,
   output logic                                 frame_start,
   output logic                                 frame_done,
   output logic [sbc_cfg_pkg::FRAME_W-1:0]      frame_in
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle bus before the first command
   initial begin
      frame_start = 1'b0;
      frame_done  = 1'b0;
      frame_in    = '0;
   end

   // one whole command; the answer is taken once it has settled
   task automatic xfer(input logic [15:0] f, input logic bad,
                       output logic [15:0] rx);
      f[PARITY_POS] = ^f[PAY_MSB:PAY_LSB] ^ bad;
      @(negedge clk);
      frame_start = 1'b1;
      frame_in    = f;
      @(negedge clk);
      frame_start = 1'b0;
      @(negedge clk);
      rx         = tx_frame;
      frame_done = 1'b1;
      @(negedge clk);
      frame_done = 1'b0;
      frame_in   = ~f; // released line must not show a stale frame
      // spacing so the pending answer is taken before the next header
      repeat (3) @(negedge clk);
   endtask : xfer
endmodule : sbc_host_model

/* File: testbench/tb.sv */
`define chk(a, e) \
   begin \
      num_checks++; \
      if ((a) !== (e)) begin \
         n_mismatch++; \
         $display("wrong value t=%0t got %h exp %h", $time, a, e); \
      end \
   end

module tb
   import sbc_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TICK = 4;

   logic clk, sys_rst, frame_start, frame_done, wd_kick, ev_host_uv;
   logic ev_wd_first, ev_wake_nack, ev_flash_ext, safe_set, leave_sleep;
   logic leave_failsafe, enter_normal, restart_by_host, strap_cfg;
   logic test_pin, threshold_sel_hi, threshold_sel_lo, undervolt_level_one;
   logic undervolt_level_two, undervolt_level_three, wd_expired;
   logic wd_fail_action, fail_safe_output, wdfail_to_safe_out;
   logic restart_cause_hi, restart_cause_lo, safe_out_cause_b2;
   logic safe_out_cause_b1, safe_out_cause_b0, strap_readout_b2;
   logic strap_readout_b1, strap_readout_b0, sw_dev_mode, ro_clear;
   logic [15:0] frame_in, tx_frame;
   logic [7:0]  wake_flags;
   logic [4:0]  wd_period;
   logic [2:0]  safe_cause_in, prev_mode, ro_clear_sel;
   logic [1:0]  rc, thr;
   logic [2:0]  sc, st, lvl;
   int          n_mismatch = 0;
   int          num_checks = 0;
   logic [3:0]  ro_seen;

   // grouped views of the loose status bits
   assign rc  = {restart_cause_hi, restart_cause_lo};
   assign thr = {threshold_sel_hi, threshold_sel_lo};
   assign sc  = {safe_out_cause_b2, safe_out_cause_b1, safe_out_cause_b0};
   assign st  = {strap_readout_b2, strap_readout_b1, strap_readout_b0};
   assign lvl = {undervolt_level_three, undervolt_level_two,
                 undervolt_level_one};

   sbc_config_diag_encoding #(.TICK_CYCLES(TICK)) i_dut (
      .clk(clk), .sys_rst(sys_rst), .frame_start(frame_start),
      .frame_done(frame_done), .frame_in(frame_in), .wd_kick(wd_kick),
      .ev_host_uv(ev_host_uv), .ev_wd_first(ev_wd_first),
      .ev_wake_nack(ev_wake_nack), .ev_flash_ext(ev_flash_ext),
      .safe_set(safe_set), .safe_cause_in(safe_cause_in),
      .leave_sleep(leave_sleep), .leave_failsafe(leave_failsafe),
      .enter_normal(enter_normal), .prev_mode(prev_mode),
      .restart_by_host(restart_by_host), .strap_cfg(strap_cfg),
      .test_pin(test_pin), .wake_flags(wake_flags), .tx_frame(tx_frame),
      .threshold_sel_hi(threshold_sel_hi),
      .threshold_sel_lo(threshold_sel_lo),
      .undervolt_level_one(undervolt_level_one),
      .undervolt_level_two(undervolt_level_two),
      .undervolt_level_three(undervolt_level_three),
      .wd_period(wd_period), .wd_expired(wd_expired),
      .wd_fail_action(wd_fail_action),
      .fail_safe_output(fail_safe_output),
      .wdfail_to_safe_out(wdfail_to_safe_out),
      .restart_cause_hi(restart_cause_hi),
      .restart_cause_lo(restart_cause_lo),
      .safe_out_cause_b2(safe_out_cause_b2),
      .safe_out_cause_b1(safe_out_cause_b1),
      .safe_out_cause_b0(safe_out_cause_b0),
      .strap_readout_b2(strap_readout_b2),
      .strap_readout_b1(strap_readout_b1),
      .strap_readout_b0(strap_readout_b0),
      .sw_dev_mode(sw_dev_mode), .ro_clear(ro_clear),
      .ro_clear_sel(ro_clear_sel));
   sbc_host_model i_host (.tx_frame(tx_frame), .clk(clk),
      .frame_start(frame_start), .frame_done(frame_done),
      .frame_in(frame_in));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // the clear strobe lasts one cycle, so keep the last one with its select
   always @(posedge clk) begin
      if (sys_rst) begin
         ro_seen <= '0;
      end else if (ro_clear) begin
         ro_seen <= {1'b1, ro_clear_sel};
      end
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic do_reset;
      @(negedge clk);
      sys_rst = 1'b1;
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge clk);
   endtask : do_reset

   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse

   task automatic wr(input logic [2:0] m, s, input logic [7:0] p,
                     output logic [15:0] rx);
      i_host.xfer({2'h0, p, s, m}, 1'b0, rx);
   endtask : wr

   // bounded wait for the next expiry; k counts the cycles it took
   task automatic wait_exp(output int k);
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (wd_expired !== 1'b1 && k < 5000);
      if (k >= 5000) begin
         n_mismatch++;
         finish_test();
      end
   endtask : wait_exp

   task automatic t_reset;
      `chk(thr, THR_RESET)
      `chk(lvl, 3'h1)
      `chk(wd_period, 5'h0F)
      `chk(wdfail_to_safe_out, WDTS_RESET)
      `chk(st, {test_pin, 1'b1, strap_cfg})
   endtask : t_reset

   task automatic t_threshold;
      logic [15:0] rx;
      logic [1:0]  last;
      last = THR_RESET;
      for (int i = 1; i < 5; i++) begin
         wr(MODE_NORMAL, SEL_CFG, {6'h02, 2'(i)}, rx);
         if (i > 1) `chk(rx, {2'h0, 6'h02, last, SEL_CFG, MODE_NORMAL})
         if (2'(i) != THR_INVALID) last = 2'(i);
         `chk(thr, last)
         `chk(lvl, 3'h1 << (last - 2'h1))
      end
   endtask : t_threshold

   // period write, refused write with bad parity, then expiry spacing
   task automatic t_wd(input logic [4:0] n, input int ms);
      logic [15:0] rx;
      int          k;
      wr(MODE_NORMAL, SEL_WD, {3'h0, n}, rx);
      i_host.xfer({2'h0, 8'h05, SEL_WD, MODE_NORMAL}, 1'b1, rx);
      `chk(wd_period, n)
      wait_exp(k);
      wait_exp(k);
      `chk(k, ms * TICK)
      `chk(wd_fail_action, ~test_pin)
   endtask : t_wd

   task automatic first(input logic [2:0] pm, input logic host,
                        input logic [15:0] e);
      logic [15:0] rx;
      prev_mode       = pm;
      restart_by_host = host;
      pulse(enter_normal);
      wr(MODE_NORMAL, SEL_COMM, 8'h00, rx);
      `chk(rx, e)
   endtask : first

   task automatic t_cause;
      logic [15:0] rx;
      logic [7:0]  dg;
      `chk(ro_seen, 4'h0)
      pulse(ev_host_uv);
      `chk(rc, RC_UV)
      wr(MODE_READ_ONLY, SEL_DIAG, 8'h00, rx);
      `chk(rx, {2'h0, 3'h2, SC_NONE, RC_UV, SEL_DIAG, MODE_READ_ONLY})
      `chk(rc, RC_NONE)
      `chk(ro_seen, {1'b1, SEL_DIAG})
      pulse(ev_wd_first);
      `chk(rc, RC_WD)
      pulse(leave_sleep);
      `chk(rc, RC_NONE)
      pulse(ev_flash_ext);
      `chk(rc, RC_EXT)
      pulse(leave_failsafe);
      `chk(rc, RC_NONE)
      pulse(ev_wake_nack);
      wr(MODE_NORMAL, SEL_DIAG, 8'h00, rx);
      `chk(rc, RC_WD)
      dg = {1'b0, 1'b1, 1'b0, SC_NONE, RC_WD};
      first(MODE_FAILSAFE, 1'b0, {2'h0, dg, SEL_DIAG, MODE_FAILSAFE});
      first(MODE_RESTART, 1'b0, {2'h0, dg, SEL_DIAG, MODE_RESTART});
      `chk(rc, RC_WD)
      first(MODE_SLEEP, 1'b0, {2'h0, wake_flags, SEL_WAKE, MODE_SLEEP});
      first(MODE_RESTART, 1'b1, {2'h0, 8'h0B, SEL_CFG, MODE_RESTART});
      first(MODE_INIT, 1'b0, {2'h0, 8'h0B, SEL_CFG, MODE_INIT});
   endtask : t_cause

   // cause codes 1 to 6, each cleared by switching the output off
   task automatic t_safe;
      logic [15:0] rx;
      for (int c = 1; c < 7; c++) begin
         safe_cause_in = 3'(c);
         pulse(safe_set);
         `chk(sc, 3'(c))
         `chk(fail_safe_output, 1'b1)
         wr(MODE_NORMAL, SEL_CFG, 8'h0B, rx);
         `chk(sc, SC_NONE)
      end
      // single-failure setting gives config one
      wr(MODE_NORMAL, SEL_CFG, 8'h03, rx);
      `chk(wdfail_to_safe_out, 1'b0)
      `chk(st, {test_pin, 1'b0, strap_cfg})
   endtask : t_safe

   task automatic t_dev;
      `chk(st, 3'h7)
      `chk(sw_dev_mode, 1'b1)
      t_wd(5'h00, 16);
   endtask : t_dev

   initial begin
      sys_rst         = 1'b1;
      {wd_kick, ev_host_uv, ev_wd_first, ev_wake_nack} = '0;
      {ev_flash_ext, safe_set, leave_sleep, leave_failsafe} = '0;
      {enter_normal, restart_by_host, strap_cfg, test_pin} = '0;
      safe_cause_in   = 3'h0;
      prev_mode       = MODE_INIT;
      wake_flags      = 8'hA5;
      do_reset();
      t_reset();
      t_threshold();
      t_wd(5'h00, 16);
      t_wd(5'h10, 304);
      t_cause();
      t_safe();
      strap_cfg = 1'b1;
      test_pin  = 1'b1;
      do_reset();
      t_dev();
      finish_test();
   end
endmodule : tb
